// file: core/mife_core.sv
// Maskable interrupt pending flags and enable masks with AXI4-Lite access
`timescale 1ns/1ps
`include "mife_cfg.svh"
// Operation
// RQ1: An arriving request sets its source's pending flag to one.
// RQ2: Writing one to a pending bit clears it, writing zero leaves it alone.
// RQ3: Writing back the value just read clears every flag that was pending.
// RQ4: A core acknowledge clears the matching pending flag.
// RQ5: A device reset clears both pending registers.
// RQ6: High pending bits 10, 9 and 8 are the rtos, datalog and buserror flags.
// RQ7: High pending bits 0 to 7 flag vectors 16 to 23.
// RQ8: Low pending bits 2 to 15 flag vectors 2 to 15, bits 1 and 0 reserved.
// RQ9: Reserved bits of all four registers read zero and ignore writes.
// RQ10: An enable bit at one enables its interrupt, at zero disables it.
// RQ11: A hardware reset clears every enable bit.
// RQ12: The software reset instruction leaves both enable registers alone.
// RQ13: Software should set the enables before clearing the global disable.
// RQ14: Enable bits mirror the pending layout and are all read/write.
// RQ15: With the global disable at one no maskable interrupt is taken.
// RQ16: An interrupt is served only when pending, enabled and not disabled.
module mife_core (
    input  wire logic               CORE_CLK,
    input  wire logic               RST_B,
    input  wire mife_pkg::mife_pair_t IRQ_REQ,
    input  wire mife_pkg::mife_pair_t IRQ_ACK,
    input  wire logic               GLOBAL_INTERRUPT_DISABLE,
    input  wire logic               SOFT_RESET,
    output mife_pkg::mife_pair_t    SERVICE,
    output logic                    IRQ,
    input  wire logic [31:0]        S_AXI_AWADDR,
    input  wire logic               S_AXI_AWVALID,
    output logic                    S_AXI_AWREADY,
    input  wire logic [31:0]        S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    input  wire logic               S_AXI_WVALID,
    output logic                    S_AXI_WREADY,
    output logic [1:0]              S_AXI_BRESP,
    output logic                    S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    input  wire logic [31:0]        S_AXI_ARADDR,
    input  wire logic               S_AXI_ARVALID,
    output logic                    S_AXI_ARREADY,
    output logic [31:0]             S_AXI_RDATA,
    output logic [1:0]              S_AXI_RRESP,
    output logic                    S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY
);
    import mife_pkg::*;

    logic        rst_meta_r;
    logic        rst_n;
    mife_state_t s_r;
    mife_state_t s_nxt;
    logic        wr_fire;
    logic [15:0] wr_mask;
    logic [15:0] wr_val;
    logic        wr_known;
    mife_pair_t  w1c;
    mife_pair_t  req;
    mife_pair_t  ack;
    logic [3:0]  ev;

    // Async assert, synchronous release
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // Only the low halfword is backed; upper lanes are ignored
    assign wr_fire = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign wr_mask = {{8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}};
    assign wr_val  = s_r.w_data[15:0] & wr_mask;
    assign wr_known = (s_r.aw_addr == `MIFE_OFS_PEND_LO)
                   || (s_r.aw_addr == `MIFE_OFS_PEND_HI)
                   || (s_r.aw_addr == `MIFE_OFS_EN_LO)
                   || (s_r.aw_addr == `MIFE_OFS_EN_HI)
                   || (s_r.aw_addr == `MIFE_OFS_EVT_STAT)
                   || (s_r.aw_addr == `MIFE_OFS_EVT_CLR)
                   || (s_r.aw_addr == `MIFE_OFS_EVT_EN);

    // Reserved positions masked off both sources and clears
    always_comb begin
        req.lo = IRQ_REQ.lo & `MIFE_MASK_LO;                    // [RQ8]
        req.hi = IRQ_REQ.hi & `MIFE_MASK_HI;                    // [RQ6] [RQ7]
        ack.lo = IRQ_ACK.lo & `MIFE_MASK_LO;
        ack.hi = IRQ_ACK.hi & `MIFE_MASK_HI;
        w1c.lo = 16'h0000;
        w1c.hi = 16'h0000;
        if (wr_fire && s_r.aw_addr == `MIFE_OFS_PEND_LO) begin
            w1c.lo = wr_val & `MIFE_MASK_LO;                    // [RQ2] [RQ9]
        end
        if (wr_fire && s_r.aw_addr == `MIFE_OFS_PEND_HI) begin
            w1c.hi = wr_val & `MIFE_MASK_HI;                    // [RQ2] [RQ9]
        end
        ev = 4'h0;
        ev[`MIFE_EVT_REQ_LO]  = |req.lo;
        ev[`MIFE_EVT_REQ_HI]  = |req.hi;
        ev[`MIFE_EVT_ACK]     = |((ack.lo & s_r.pend.lo)
                                 | (ack.hi & s_r.pend.hi));
        ev[`MIFE_EVT_OVERRUN] = |((req.lo & s_r.pend.lo)
                                 | (req.hi & s_r.pend.hi));
    end

    always_comb begin
        s_nxt = s_r;
        // Request beats a same-cycle clear or acknowledge
        s_nxt.pend.lo = (s_r.pend.lo & ~w1c.lo & ~ack.lo)       // [RQ3] [RQ4]
                      | req.lo;                                 // [RQ1]
        s_nxt.pend.hi = (s_r.pend.hi & ~w1c.hi & ~ack.hi)       // [RQ3] [RQ4]
                      | req.hi;                                 // [RQ1]
        if (SOFT_RESET) begin
            s_nxt.pend.lo = req.lo;
            s_nxt.pend.hi = req.hi;
        end
        s_nxt.evt = s_r.evt | ev;
        if (wr_fire) begin
            unique case (s_r.aw_addr)
                `MIFE_OFS_EN_LO: begin
                    s_nxt.en.lo = ((s_r.en.lo & ~wr_mask) | wr_val)
                                & `MIFE_MASK_LO;                // [RQ10] [RQ14]
                end
                `MIFE_OFS_EN_HI: begin
                    s_nxt.en.hi = ((s_r.en.hi & ~wr_mask) | wr_val)
                                & `MIFE_MASK_HI;                // [RQ10] [RQ14]
                end
                `MIFE_OFS_EVT_CLR: begin
                    s_nxt.evt = (s_r.evt & ~wr_val[3:0]) | ev;
                end
                `MIFE_OFS_EVT_EN: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.evt_en = s_r.w_data[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Soft reset leaves en untouched on purpose              [RQ12]
        s_nxt.serve.lo = s_nxt.pend.lo & s_nxt.en.lo            // [RQ16]
                       & {16{~GLOBAL_INTERRUPT_DISABLE}};       // [RQ15]
        s_nxt.serve.hi = s_nxt.pend.hi & s_nxt.en.hi            // [RQ16]
                       & {16{~GLOBAL_INTERRUPT_DISABLE}};       // [RQ15]
        s_nxt.irq = |(s_nxt.evt & s_nxt.evt_en);

        // Write channel: address and data latched in either order
        if (S_AXI_AWVALID && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = S_AXI_WDATA;
            s_nxt.w_strb = S_AXI_WSTRB;
        end
        if (s_r.bvalid && S_AXI_BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = wr_known ? `MIFE_RESP_OKAY : `MIFE_RESP_SLVERR;
        end
        s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;

        // Read channel: one outstanding read, data one edge after address
        if (s_r.rvalid && S_AXI_RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = `MIFE_RESP_OKAY;
            s_nxt.rdata  = 32'h0000_0000;                       // [RQ9]
            unique case (S_AXI_ARADDR)
                `MIFE_OFS_PEND_LO:  s_nxt.rdata[15:0] = s_r.pend.lo;
                `MIFE_OFS_PEND_HI:  s_nxt.rdata[15:0] = s_r.pend.hi;
                `MIFE_OFS_EN_LO:    s_nxt.rdata[15:0] = s_r.en.lo;
                `MIFE_OFS_EN_HI:    s_nxt.rdata[15:0] = s_r.en.hi;
                `MIFE_OFS_EVT_STAT: s_nxt.rdata[3:0]  = s_r.evt;
                `MIFE_OFS_EVT_CLR:  s_nxt.rdata[3:0]  = 4'h0;
                `MIFE_OFS_EVT_EN:   s_nxt.rdata[3:0]  = s_r.evt_en;
                default:            s_nxt.rresp = `MIFE_RESP_SLVERR;
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;
    end

    // Flags and enables both start at zero out of reset
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_r         <= '0;
            s_r.pend.lo <= `MIFE_RST_REG16;                     // [RQ5]
            s_r.pend.hi <= `MIFE_RST_REG16;                     // [RQ5]
            s_r.en.lo   <= `MIFE_RST_REG16;                     // [RQ11]
            s_r.en.hi   <= `MIFE_RST_REG16;                     // [RQ11]
            s_r.evt     <= `MIFE_RST_EVT;
            s_r.evt_en  <= `MIFE_RST_EVT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign SERVICE       = s_r.serve;
    assign IRQ           = s_r.irq;
    assign S_AXI_AWREADY = s_r.awready;
    assign S_AXI_WREADY  = s_r.wready;
    assign S_AXI_BVALID  = s_r.bvalid;
    assign S_AXI_BRESP   = s_r.bresp;
    assign S_AXI_ARREADY = s_r.arready;
    assign S_AXI_RVALID  = s_r.rvalid;
    assign S_AXI_RDATA   = s_r.rdata;
    assign S_AXI_RRESP   = s_r.rresp;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n);

    property p_req_sets;
        (|req.lo) |=> ((s_r.pend.lo & $past(req.lo)) == $past(req.lo));
    endproperty
    a_req_sets: assert property (p_req_sets)                    // [RQ1]
        else $error("Request did not set its pending flag");

    property p_w1c_clears;
        (|w1c.hi) && !(|IRQ_REQ.hi)
            |=> ((s_r.pend.hi & $past(w1c.hi)) == 16'h0000);
    endproperty
    a_w1c_clears: assert property (p_w1c_clears)                // [RQ2]
        else $error("Write of one left a pending flag set");

    property p_writeback;
        wr_fire && s_r.aw_addr == `MIFE_OFS_PEND_LO
            && s_r.w_strb[1:0] == 2'b11
            && s_r.w_data[15:0] == s_r.pend.lo && !SOFT_RESET
            |=> s_r.pend.lo == $past(req.lo);
    endproperty
    a_writeback: assert property (p_writeback)                  // [RQ3]
        else $error("Write-back of pending value did not clear it");

    property p_ack_clears;
        (|(ack.hi & ~req.hi)) |=> ((s_r.pend.hi
            & $past(ack.hi) & ~$past(req.hi)) == 16'h0000);
    endproperty
    a_ack_clears: assert property (p_ack_clears)                // [RQ4]
        else $error("Acknowledge left its pending flag set");

    property p_reset_zero;
        $rose(rst_n) |-> (s_r.pend == '0) && (s_r.en == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)                // [RQ5] [RQ11]
        else $error("Flags or enables not zero after reset");

    property p_reserved;
        ((s_r.pend.lo | s_r.en.lo) & ~`MIFE_MASK_LO) == 16'h0000
        && ((s_r.pend.hi | s_r.en.hi) & ~`MIFE_MASK_HI) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)                    // [RQ9]
        else $error("Reserved bit holds a one");

    property p_en_write;
        wr_fire && s_r.aw_addr == `MIFE_OFS_EN_HI
            && s_r.w_strb[1:0] == 2'b11
            |=> s_r.en.hi == ($past(s_r.w_data[15:0]) & `MIFE_MASK_HI);
    endproperty
    a_en_write: assert property (p_en_write)                    // [RQ10] [RQ14]
        else $error("Enable register did not take written value");

    property p_soft_keeps_en;
        SOFT_RESET && !wr_fire |=> $stable(s_r.en);
    endproperty
    a_soft_keeps_en: assert property (p_soft_keeps_en)          // [RQ12]
        else $error("Soft reset changed an enable bit");

    property p_global_off;
        GLOBAL_INTERRUPT_DISABLE |=> SERVICE == '0;
    endproperty
    a_global_off: assert property (p_global_off)                // [RQ15]
        else $error("Interrupt served while globally disabled");

    property p_serve;
        !$past(GLOBAL_INTERRUPT_DISABLE)
            |-> SERVICE == (s_r.pend & s_r.en);
    endproperty
    a_serve: assert property (p_serve)                          // [RQ16]
        else $error("Service output does not match flag and enable");

    property p_bvalid_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("Write response dropped before accepted");

    property p_req_sets_hi;
        (|req.hi) |=> ((s_r.pend.hi & $past(req.hi)) == $past(req.hi));
    endproperty
    a_req_sets_hi: assert property (p_req_sets_hi)              // [RQ1]
        else $error("Request did not set its high pending flag");

    property p_w1c_clears_lo;
        (|w1c.lo) && !(|IRQ_REQ.lo)
            |=> ((s_r.pend.lo & $past(w1c.lo)) == 16'h0000);
    endproperty
    a_w1c_clears_lo: assert property (p_w1c_clears_lo)          // [RQ2]
        else $error("Write of one left a low pending flag set");

    property p_w0_keeps;
        wr_fire && s_r.aw_addr == `MIFE_OFS_PEND_LO && !SOFT_RESET
            && !(|ack.lo)
            |=> (($past(s_r.pend.lo) & ~$past(w1c.lo) & ~s_r.pend.lo)
                 == 16'h0000);
    endproperty
    a_w0_keeps: assert property (p_w0_keeps)                    // [RQ2]
        else $error("Write of zero cleared a pending flag");

    property p_ack_clears_lo;
        (|(ack.lo & ~req.lo)) |=> ((s_r.pend.lo
            & $past(ack.lo) & ~$past(req.lo)) == 16'h0000);
    endproperty
    a_ack_clears_lo: assert property (p_ack_clears_lo)          // [RQ4]
        else $error("Acknowledge left a low pending flag set");

    property p_soft_clears;
        SOFT_RESET |=> s_r.pend == $past(req);
    endproperty
    a_soft_clears: assert property (p_soft_clears)              // [RQ5]
        else $error("Soft reset left a pending flag set");

    property p_en_write_lo;
        wr_fire && s_r.aw_addr == `MIFE_OFS_EN_LO
            && s_r.w_strb[1:0] == 2'b11
            |=> s_r.en.lo == ($past(s_r.w_data[15:0]) & `MIFE_MASK_LO);
    endproperty
    a_en_write_lo: assert property (p_en_write_lo)              // [RQ14]
        else $error("Low enable register did not take written value");

    property p_en_hold;
        !(wr_fire && (s_r.aw_addr == `MIFE_OFS_EN_LO
            || s_r.aw_addr == `MIFE_OFS_EN_HI))
            |=> $stable(s_r.en);
    endproperty
    a_en_hold: assert property (p_en_hold)                      // [RQ10]
        else $error("Enable bit changed without a write");

    property p_serve_subset;
        (SERVICE & ~(s_r.pend & s_r.en)) == 32'h0000_0000;
    endproperty
    a_serve_subset: assert property (p_serve_subset)            // [RQ16]
        else $error("Service bit set without flag and enable");

    property p_irq_level;
        IRQ == |(s_r.evt & s_r.evt_en);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt output does not follow enabled status");

    property p_evt_sticky;
        (|ev) |=> ((s_r.evt & $past(ev)) == $past(ev));
    endproperty
    a_evt_sticky: assert property (p_evt_sticky)
        else $error("Event status bit lost in its setting cycle");

    property p_rvalid_hold;
        S_AXI_RVALID && !S_AXI_RREADY
            |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("Read data dropped before accepted");

    property p_w_refused;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_w_refused: assert property (p_w_refused)
        else $error("Write offered ready while a response is pending");

    property p_r_refused;
        S_AXI_RVALID |-> !S_AXI_ARREADY;
    endproperty
    a_r_refused: assert property (p_r_refused)
        else $error("Read offered ready while data is pending");

    property p_b_follows;
        wr_fire |=> S_AXI_BVALID;
    endproperty
    a_b_follows: assert property (p_b_follows)
        else $error("Write response missing after both halves taken");
endmodule

// file: core/mife_cfg.svh
// Register offsets, field positions, masks and reset values
`ifndef MIFE_CFG_SVH
`define MIFE_CFG_SVH
`define MIFE_OFS_PEND_LO    32'h0000_0000
`define MIFE_OFS_PEND_HI    32'h0000_0004
`define MIFE_OFS_EN_LO      32'h0000_0008
`define MIFE_OFS_EN_HI      32'h0000_000c
`define MIFE_OFS_EVT_STAT   32'h0000_0010
`define MIFE_OFS_EVT_CLR    32'h0000_0014
`define MIFE_OFS_EVT_EN     32'h0000_0018
`define MIFE_MASK_LO        16'hfffc
`define MIFE_MASK_HI        16'h07ff
`define MIFE_BIT_RTOS       10
`define MIFE_BIT_DLOG       9
`define MIFE_BIT_BERR       8
`define MIFE_BIT_VEC16      0
`define MIFE_BIT_VEC2       2
`define MIFE_RST_REG16      16'h0000
`define MIFE_EVT_REQ_LO     0
`define MIFE_EVT_REQ_HI     1
`define MIFE_EVT_ACK        2
`define MIFE_EVT_OVERRUN    3
`define MIFE_RST_EVT        4'h0
`define MIFE_RESP_OKAY      2'b00
`define MIFE_RESP_SLVERR    2'b10
`endif

// file: core/mife_pkg.sv
// Types shared by the interrupt flag and enable block
package mife_pkg;
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } mife_pair_t;

    typedef struct packed {
        mife_pair_t  pend;
        mife_pair_t  en;
        logic [3:0]  evt;
        logic [3:0]  evt_en;
        mife_pair_t  serve;
        logic        irq;
        logic        aw_held;
        logic [31:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mife_state_t;
endpackage

// file: test/mife_partner.sv
// Request sources and core acknowledge model
`timescale 1ns/1ps
module mife_partner (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire mife_pkg::mife_pair_t req_cmd,
    input  wire logic                 ack_on,
    input  wire logic [3:0]           ack_wait,
    input  wire mife_pkg::mife_pair_t service,
    output mife_pkg::mife_pair_t      irq_req,
    output mife_pkg::mife_pair_t      irq_ack
);
    import mife_pkg::*;
    logic [3:0] cnt_r;
    // Sources already change just after the edge, so pass straight through
    assign irq_req = req_cmd;
    // One ack at a time, lowest served bit; waits out the stale cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r   <= 4'h0;
            irq_ack <= '0;
        end else begin
            irq_ack <= '0;
            if (!ack_on || service == '0 || irq_ack != '0) begin
                cnt_r <= 4'h0;
            end else if (cnt_r < ack_wait) begin
                cnt_r <= cnt_r + 4'h1;
            end else begin
                irq_ack <= service & (~service + 32'h1);
                cnt_r   <= 4'h0;
            end
        end
    end
endmodule

// file: test/test_mife_core.sv
// Self-checking bench for the interrupt flag and enable block
`timescale 1ns/1ps
`include "mife_cfg.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_mife_core;
    import mife_pkg::*;
    typedef struct packed {
        logic [31:0] a;
        logic [15:0] d;
        logic [15:0] q;
        logic [1:0]  r;
    } mife_row_t;
    // Starts high so time zero gives a real reset edge
    logic        clk = 1'b0, rst_b = 1'b1, gid = 1'b1, srst = 1'b0;
    logic        ack_on = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
    logic        arv = 1'b0, rr = 1'b0, irq, awr, wrdy, bv, arr, rv;
    logic [3:0]  ack_wait = 4'h0, strb = 4'hf;
    logic [31:0] awa = '0, wd = '0, ara = '0, rdat, q;
    logic [1:0]  bresp, rresp, r;
    mife_pair_t  req_cmd = '0, irq_req, irq_ack, service;
    int          failures = 0, n_tests = 0;
    mife_row_t   rows [9] = '{
        '{`MIFE_OFS_EN_LO, 16'hffff, 16'hfffc, `MIFE_RESP_OKAY},
        '{`MIFE_OFS_EN_HI, 16'hffff, 16'h07ff, `MIFE_RESP_OKAY},
        '{`MIFE_OFS_EN_HI, 16'h0a5a, 16'h025a, `MIFE_RESP_OKAY},
        '{`MIFE_OFS_EN_LO, 16'h1234, 16'h1234, `MIFE_RESP_OKAY},
        '{`MIFE_OFS_EN_LO, 16'h0003, 16'h0000, `MIFE_RESP_OKAY},
        '{`MIFE_OFS_PEND_LO, 16'hffff, 16'h0000, `MIFE_RESP_OKAY},
        '{`MIFE_OFS_EVT_CLR, 16'hffff, 16'h0000, `MIFE_RESP_OKAY},
        '{32'h0000_001c, 16'hffff, 16'h0000, `MIFE_RESP_SLVERR},
        '{`MIFE_OFS_EVT_EN, 16'h00ff, 16'h000f, `MIFE_RESP_OKAY}
    };

    mife_core u_dut (
        .CORE_CLK(clk), .RST_B(rst_b), .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack),
        .GLOBAL_INTERRUPT_DISABLE(gid), .SOFT_RESET(srst),
        .SERVICE(service), .IRQ(irq),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr)
    );
    mife_partner u_src (
        .clk(clk), .rst_b(rst_b), .req_cmd(req_cmd), .ack_on(ack_on),
        .ack_wait(ack_wait), .service(service), .irq_req(irq_req),
        .irq_ack(irq_ack)
    );

    initial forever #20 clk = ~clk;

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        awa <= a;
        wd  <= {16'h0000, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        r = bresp;
        br <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        q = rdat;
        r = rresp;
        rr <= 1'b0;
    endtask

    // One-cycle request burst; returns just after the sampling edge
    task automatic fire(input mife_pair_t v);
        @(posedge clk);
        req_cmd <= v;
        @(posedge clk);
        req_cmd <= '0;
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        for (int k = 0; k < 60 && service !== '0; k++) @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 16; i += 4) begin
            rd(32'(i));
            `CHK("reset value", 16'h0000, q[15:0])
        end
        $display("reset values done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            `CHK("write resp", rows[i].r, r)
            rd(rows[i].a);
            `CHK("read data", rows[i].q, q[15:0])
            `CHK("read resp", rows[i].r, r)
        end
        $display("register table done");
        wr(`MIFE_OFS_EN_HI, 16'hffff);
        fire('1);
        `CHK("service masked", 32'h0, service)
        rd(`MIFE_OFS_PEND_LO);
        `CHK("pend lo", 16'hfffc, q[15:0])
        rd(`MIFE_OFS_PEND_HI);
        `CHK("pend hi", 16'h07ff, q[15:0])
        wr(`MIFE_OFS_PEND_LO, 16'h4004);
        rd(`MIFE_OFS_PEND_LO);
        `CHK("w1c lo", 16'hbff8, q[15:0])
        wr(`MIFE_OFS_PEND_LO, q[15:0]);
        rd(`MIFE_OFS_PEND_LO);
        `CHK("write back", 16'h0000, q[15:0])
        $display("flag set and clear done");
        gid <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("service", 32'h07ff_0000, service)
        wr(`MIFE_OFS_EN_HI, 16'h0400);
        @(posedge clk);
        #1;
        `CHK("service enable", 32'h0400_0000, service)
        ack_on   <= 1'b1;
        ack_wait <= 4'h3;
        settle();
        rd(`MIFE_OFS_PEND_HI);
        `CHK("slow ack", 16'h03ff, q[15:0])
        ack_wait <= 4'h0;
        wr(`MIFE_OFS_EN_HI, 16'h07ff);
        settle();
        rd(`MIFE_OFS_PEND_HI);
        `CHK("prompt ack", 16'h0000, q[15:0])
        ack_on <= 1'b0;
        $display("service and ack done");
        rd(`MIFE_OFS_EVT_STAT);
        `CHK("ack event", 16'h0007, q[15:0])
        wr(`MIFE_OFS_EVT_CLR, 16'h000f);
        wr(`MIFE_OFS_EVT_EN, 16'h0001);
        fire('1);
        `CHK("irq raised", 1'b1, irq)
        rd(`MIFE_OFS_EVT_STAT);
        `CHK("event status", 16'h0003, q[15:0])
        fire('1);
        rd(`MIFE_OFS_EVT_STAT);
        `CHK("overrun event", 16'h000b, q[15:0])
        wr(`MIFE_OFS_EVT_EN, 16'h0000);
        @(posedge clk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        wr(`MIFE_OFS_EVT_CLR, 16'h000f);
        rd(`MIFE_OFS_EVT_STAT);
        `CHK("event cleared", 16'h0000, q[15:0])
        $display("interrupt done");
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd(`MIFE_OFS_EN_HI);
        `CHK("soft keeps en", 16'h07ff, q[15:0])
        rd(`MIFE_OFS_PEND_LO);
        `CHK("soft clears pend", 16'h0000, q[15:0])
        strb <= 4'h1;
        wr(`MIFE_OFS_EN_LO, 16'hffff);
        strb <= 4'hf;
        rd(`MIFE_OFS_EN_LO);
        `CHK("byte strobe", 16'h00fc, q[15:0])
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(`MIFE_OFS_EN_HI);
        `CHK("hard reset en", 16'h0000, q[15:0])
        rd(`MIFE_OFS_EN_LO);
        `CHK("hard reset en lo", 16'h0000, q[15:0])
        $display("resets done");
        print_verdict();
    end
endmodule
